// >>> src/mcu_arith_logic_unit.sv
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module mcu_arith_logic_unit
  import alu_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic      [1:0]        bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic      [31:0]       rdata,
  output logic      [1:0]        rresp,
  output logic                   rvalid,
  input  wire logic              rready
);
  import alu_pkg::*;

  if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 6 and 32");
  end

  typedef enum logic [1:0] {IDLE, EXEC, EXEC2} state_t;

  logic              awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic              arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [ADDR_W-1:0] awAddr_q, awAddr_d;
  logic [31:0]       wData_q, wData_d, rdata_q, rdata_d;
  logic [3:0]        wStrb_q, wStrb_d;
  logic              doWrite;
  logic              start;

  state_t            state_q, state_d;
  op_t               op_q, op_d;
  logic [7:0]        dst_q, dst_d, src_q, src_d, lo_q, lo_d;
  logic [15:0]       word_q, word_d, r10_q, r10_d;
  logic [FLAG_W-1:0] flags_q, flags_d;
  logic              loCarry_q, loCarry_d;

  logic [7:0]        asA, asB, asRes;
  logic              asCin, asSub, asCarry, asHalf, asOvf;

  mul_if mulBus ();

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] off);
    hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(off[4:2]));
  endfunction

  function automatic logic [15:0] lanes(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [1:0] strb);
    lanes = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction

  byte_add_sub u_addsub (
    .a     (asA),
    .b     (asB),
    .cin   (asCin),
    .sub   (asSub),
    .res   (asRes),
    .carry (asCarry),
    .half  (asHalf),
    .ovf   (asOvf)
  );

  mul_unit u_mul (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .mb      (mulBus.unit)
  );

  assign mulBus.a       = dst_q;
  assign mulBus.b       = src_q;
  assign mulBus.aSigned = op_q inside {OP_PROD_SIGNED, OP_PROD_MIXED, OP_FRAC_SIGNED,
                                       OP_FRAC_MIXED};
  assign mulBus.bSigned = op_q inside {OP_PROD_SIGNED, OP_FRAC_SIGNED};
  assign mulBus.frac    = op_q inside {OP_FMULU, OP_FRAC_SIGNED, OP_FRAC_MIXED};

  // Address and data held until both arrived and the response slot is free
  assign doWrite = ~awready_q & ~wready_q & ~bvalid_q;
  assign start   = doWrite & hit(awAddr_q, OFF_CMD) & wStrb_q[0] & (state_q == IDLE)
                   & (wData_q[4:0] < OP_COUNT);

  always_comb begin
    awready_d = awready_q;
    wready_d  = wready_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    awAddr_d  = awAddr_q;
    wData_d   = wData_q;
    wStrb_d   = wStrb_q;
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (awvalid && awready_q) begin
      awAddr_d  = awaddr;
      awready_d = 1'b0;
    end
    if (wvalid && wready_q) begin
      wData_d  = wdata;
      wStrb_d  = wstrb;
      wready_d = 1'b0;
    end
    if (doWrite) begin
      awready_d = 1'b1;
      wready_d  = 1'b1;
      bvalid_d  = 1'b1;
      bresp_d   = (hit(awAddr_q, OFF_OPND) || hit(awAddr_q, OFF_WORD) ||
                   hit(awAddr_q, OFF_CMD) || hit(awAddr_q, OFF_FLAGS) ||
                   hit(awAddr_q, OFF_PROD)) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = RESP_OKAY;
      rdata_d   = 32'h00000000;
      if (hit(araddr, OFF_OPND)) begin
        rdata_d[15:0] = {src_q, dst_q};
      end else if (hit(araddr, OFF_WORD)) begin
        rdata_d[15:0] = word_q;
      end else if (hit(araddr, OFF_CMD)) begin
        rdata_d[4:0]     = op_q;
        rdata_d[BUSY_BIT] = (state_q != IDLE);
      end else if (hit(araddr, OFF_FLAGS)) begin
        rdata_d[FLAG_W-1:0] = flags_q;
      end else if (hit(araddr, OFF_PROD)) begin
        rdata_d[15:0] = r10_q;
      end else begin
        rresp_d = RESP_SLVERR;
      end
    end
    if (rvalid_q && rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awAddr_q  <= '0;
      wData_q   <= 32'h00000000;
      wStrb_q   <= 4'h0;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= RESP_OKAY;
    end else begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      awAddr_q  <= awAddr_d;
      wData_q   <= wData_d;
      wStrb_q   <= wStrb_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // Operand selection for the shared byte adder
  always_comb begin
    asA   = dst_q;
    asB   = src_q;
    asCin = 1'b0;
    asSub = 1'b0;
    case (op_q)
      OP_ADC: asCin = flags_q[FLG_BORROW];
      OP_SUB: asSub = 1'b1;
      OP_DIFF_BORROW: begin
        asSub = 1'b1;
        asCin = flags_q[FLG_BORROW];
      end
      OP_SIGN_FLIP: begin
        asA   = ALL_ZERO;
        asB   = dst_q;
        asSub = 1'b1;
      end
      OP_INC: asB = ONE;
      OP_MINUS_ONE: begin
        asB   = ONE;
        asSub = 1'b1;
      end
      OP_WADD, OP_WSUB: begin
        asSub = (op_q == OP_WSUB);
        asA   = (state_q == EXEC2) ? word_q[15:8] : word_q[7:0];
        asB   = (state_q == EXEC2) ? ALL_ZERO : src_q;
        asCin = (state_q == EXEC2) ? loCarry_q : 1'b0;
      end
      default: asSub = 1'b0;
    endcase
  end

  always_comb begin
    logic [7:0]        r;
    logic [FLAG_W-1:0] nf;
    logic [FLAG_W-1:0] um;
    logic              wr;
    r  = asRes;
    nf = '0;
    um = '0;
    wr = 1'b0;
    state_d   = state_q;
    op_d      = op_q;
    dst_d     = dst_q;
    src_d     = src_q;
    word_d    = word_q;
    r10_d     = r10_q;
    lo_d      = lo_q;
    loCarry_d = loCarry_q;
    case (state_q)
      IDLE: begin
        if (doWrite && hit(awAddr_q, OFF_OPND)) begin
          {src_d, dst_d} = lanes({src_q, dst_q}, wData_q[15:0], wStrb_q[1:0]);
        end
        if (doWrite && hit(awAddr_q, OFF_WORD)) begin
          word_d = lanes(word_q, wData_q[15:0], wStrb_q[1:0]);
        end
        if (doWrite && hit(awAddr_q, OFF_FLAGS) && wStrb_q[0]) begin
          nf = wData_q[FLAG_W-1:0];
          um = '1;
        end
        if (start) begin
          op_d    = op_t'(wData_q[4:0]);
          state_d = EXEC;
        end
      end
      EXEC: begin
        state_d = IDLE;
        wr      = 1'b1;
        case (op_q)
          OP_ADD, OP_ADC, OP_SUB, OP_DIFF_BORROW, OP_SIGN_FLIP: begin
            nf[FLG_BORROW] = asCarry;
            nf[FLG_NIBBLE] = asHalf;
            nf[FLG_SPILL]  = asOvf;
            um = '1;
            um[FLG_POL] = 1'b0;
          end
          OP_AND: r = dst_q & src_q;
          OP_OR, OP_SETB: r = dst_q | src_q;
          OP_XOR: r = dst_q ^ src_q;
          OP_CLRB: r = dst_q & (ALL_ONES - src_q);
          OP_ZM_TEST: r = dst_q & dst_q;
          OP_ZERO: r = dst_q ^ dst_q;
          OP_INC, OP_MINUS_ONE: nf[FLG_SPILL] = asOvf;
          OP_INV: begin
            r = ALL_ONES - dst_q;
            nf[FLG_BORROW] = 1'b1;
            um[FLG_BORROW] = 1'b1;
          end
          OP_FILL: begin
            r  = ALL_ONES;
            um = '0;
          end
          default: begin
            wr        = 1'b0;
            state_d   = EXEC2;
            lo_d      = asRes;
            loCarry_d = asCarry;
          end
        endcase
        if (op_q inside {OP_AND, OP_OR, OP_SETB, OP_XOR, OP_CLRB, OP_ZM_TEST, OP_ZERO,
                         OP_INC, OP_MINUS_ONE, OP_INV}) begin
          um[FLG_NIL]   = 1'b1;
          um[FLG_MSB]   = 1'b1;
          um[FLG_SPILL] = 1'b1;
        end
        nf[FLG_NIL] = (r == ALL_ZERO);
        nf[FLG_MSB] = r[7];
        if (wr) begin
          dst_d = r;
        end
      end
      EXEC2: begin
        state_d = IDLE;
        if (op_q inside {OP_WADD, OP_WSUB}) begin
          word_d         = {asRes, lo_q};
          nf[FLG_NIL]    = ({asRes, lo_q} == WORD_RST);
          nf[FLG_BORROW] = asCarry;
          nf[FLG_MSB]    = asRes[7];
          nf[FLG_SPILL]  = asOvf;
          nf[FLG_POL]    = asRes[7] ^ asOvf;
          um             = '1;
          um[FLG_NIBBLE] = 1'b0;
        end else begin
          r10_d          = mulBus.prod;
          nf[FLG_NIL]    = mulBus.zero;
          nf[FLG_BORROW] = mulBus.carry;
          um[FLG_NIL]    = 1'b1;
          um[FLG_BORROW] = 1'b1;
        end
      end
      default: state_d = IDLE;
    endcase
    flags_d = (flags_q & ~um) | (nf & um);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= IDLE;
      op_q      <= OP_ADD;
      dst_q     <= BYTE_RST;
      src_q     <= BYTE_RST;
      word_q    <= WORD_RST;
      r10_q     <= WORD_RST;
      flags_q   <= FLAGS_RST;
      lo_q      <= BYTE_RST;
      loCarry_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      op_q      <= op_d;
      dst_q     <= dst_d;
      src_q     <= src_d;
      word_q    <= word_d;
      r10_q     <= r10_d;
      flags_q   <= flags_d;
      lo_q      <= lo_d;
      loCarry_q <= loCarry_d;
    end
  end

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  chk_add_sum: assert property (
    state_q == EXEC && op_q == OP_ADC |=> dst_q == $past(dst_q) + $past(src_q)
      + {7'h00, $past(flags_q[FLG_BORROW])} && state_q == IDLE)
    else $error("byte add with carry wrong");
  chk_word_add: assert property (
    state_q == EXEC && op_q == OP_WADD |=> state_q == EXEC2 ##1
      word_q == $past(word_q, 2) + {8'h00, $past(src_q, 2)} && state_q == IDLE)
    else $error("word add wrong or not two cycles");
  chk_sub_diff: assert property (
    state_q == EXEC && op_q == OP_SUB |=> dst_q == $past(dst_q) - $past(src_q)
      && flags_q[FLG_BORROW] == ($past(src_q) > $past(dst_q)))
    else $error("byte subtract wrong");
  chk_borrow_diff: assert property (
    state_q == EXEC && op_q == OP_DIFF_BORROW |=> dst_q == $past(dst_q) - $past(src_q)
      - {7'h00, $past(flags_q[FLG_BORROW])})
    else $error("subtract with carry wrong");
  chk_word_sub: assert property (
    state_q == EXEC && op_q == OP_WSUB |-> ##2 word_q == $past(word_q, 2)
      - {8'h00, $past(src_q, 2)} && flags_q[FLG_POL] == (flags_q[FLG_MSB] ^ flags_q[FLG_SPILL]))
    else $error("word subtract wrong");
  chk_and_flags: assert property (
    state_q == EXEC && op_q == OP_AND |=> dst_q == ($past(dst_q) & $past(src_q))
      && !flags_q[FLG_SPILL] && $stable(flags_q[FLG_BORROW]))
    else $error("and result or flags wrong");
  chk_or_result: assert property (
    state_q == EXEC && op_q == OP_OR |=> dst_q == ($past(dst_q) | $past(src_q))
      && flags_q[FLG_NIL] == (dst_q == ALL_ZERO))
    else $error("or result wrong");
  chk_xor_result: assert property (
    state_q == EXEC && op_q == OP_XOR |=> dst_q == ($past(dst_q) ^ $past(src_q))
      && $stable(flags_q[FLG_NIBBLE]))
    else $error("xor result wrong");
  chk_invert_carry: assert property (
    state_q == EXEC && op_q == OP_INV |=> dst_q == ~$past(dst_q) && flags_q[FLG_BORROW])
    else $error("invert wrong");
  chk_clear_bits: assert property (
    state_q == EXEC && op_q == OP_CLRB |=> dst_q == ($past(dst_q) & ~$past(src_q)))
    else $error("clear bits wrong");
  chk_mul_product: assert property (
    state_q == EXEC && op_q == OP_MULU |-> ##2
      r10_q == {8'h00, $past(dst_q, 2)} * {8'h00, $past(src_q, 2)}
      && flags_q[FLG_NIL] == (r10_q == WORD_RST))
    else $error("unsigned product wrong");
  chk_frac_product: assert property (
    state_q == EXEC && op_q == OP_FMULU |-> ##2
      r10_q == 16'({8'h00, $past(dst_q, 2)} * {8'h00, $past(src_q, 2)} << 1))
    else $error("fractional product wrong");
  chk_fill_flags: assert property (
    state_q == EXEC && op_q == OP_FILL |=> dst_q == ALL_ONES && $stable(flags_q))
    else $error("fill ones changed flags");
  chk_commit_last: assert property (
    state_q == EXEC && op_q inside {OP_WADD, OP_PROD_SIGNED}
      |=> $stable(flags_q) && $stable(word_q))
    else $error("two-cycle result committed early");
endmodule

// >>> src/alu_pkg.sv
package alu_pkg;

  localparam logic [4:0] OFF_OPND  = 5'h00;
  localparam logic [4:0] OFF_WORD  = 5'h04;
  localparam logic [4:0] OFF_CMD   = 5'h08;
  localparam logic [4:0] OFF_FLAGS = 5'h0c;
  localparam logic [4:0] OFF_PROD  = 5'h10;

  localparam int unsigned FLAG_W     = 6;
  localparam int unsigned FLG_BORROW = 0;
  localparam int unsigned FLG_NIL    = 1;
  localparam int unsigned FLG_MSB    = 2;
  localparam int unsigned FLG_SPILL  = 3;
  localparam int unsigned FLG_POL    = 4;
  localparam int unsigned FLG_NIBBLE = 5;
  localparam int unsigned BUSY_BIT   = 8;

  localparam logic [7:0]        BYTE_RST  = 8'h00;
  localparam logic [15:0]       WORD_RST  = 16'h0000;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 6'h00;
  localparam logic [7:0]        ALL_ONES  = 8'hff;
  localparam logic [7:0]        ALL_ZERO  = 8'h00;
  localparam logic [7:0]        ONE       = 8'h01;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    OP_ADD, OP_ADC, OP_WADD, OP_SUB, OP_DIFF_BORROW, OP_WSUB,
    OP_AND, OP_OR, OP_XOR, OP_INV, OP_SIGN_FLIP, OP_SETB, OP_CLRB,
    OP_INC, OP_MINUS_ONE, OP_ZM_TEST, OP_ZERO, OP_FILL,
    OP_MULU, OP_PROD_SIGNED, OP_PROD_MIXED, OP_FMULU, OP_FRAC_SIGNED, OP_FRAC_MIXED
  } op_t;

  localparam logic [4:0] OP_COUNT = 5'h18;

endpackage

// >>> src/mul_if.sv
`timescale 1ns/1ps
interface mul_if;
  logic [7:0]  a;
  logic [7:0]  b;
  logic        aSigned;
  logic        bSigned;
  logic        frac;
  logic [15:0] prod;
  logic        zero;
  logic        carry;
  modport ctrl (output a, b, aSigned, bSigned, frac, input prod, zero, carry);
  modport unit (input a, b, aSigned, bSigned, frac, output prod, zero, carry);
endinterface

// >>> src/mul_unit.sv
`timescale 1ns/1ps
module mul_unit (
  input wire logic sys_clk,
  input wire logic resetn,
  mul_if.unit      mb
);
  logic signed [17:0] full;
  logic [15:0]        prod_d;
  logic [15:0]        prod_q;
  logic               carry_d;
  logic               carry_q;

  // Nine-bit operands so one signed multiplier serves all three sign modes
  always_comb begin
    full    = 18'($signed({mb.aSigned & mb.a[7], mb.a}))
              * 18'($signed({mb.bSigned & mb.b[7], mb.b}));
    carry_d = full[15];
    prod_d  = mb.frac ? {full[14:0], 1'b0} : full[15:0];
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prod_q  <= 16'h0000;
      carry_q <= 1'b0;
    end else begin
      prod_q  <= prod_d;
      carry_q <= carry_d;
    end
  end

  assign mb.prod  = prod_q;
  assign mb.zero  = (prod_q == 16'h0000);
  assign mb.carry = carry_q;
endmodule

// >>> src/byte_add_sub.sv
`timescale 1ns/1ps
module byte_add_sub (
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  input  wire logic       sub,
  output logic      [7:0] res,
  output logic            carry,
  output logic            half,
  output logic            ovf
);
  logic [8:0] full;
  logic [4:0] nib;

  always_comb begin
    if (sub) begin
      full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      nib  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      ovf  = (a[7] & ~b[7] & ~full[7]) | (~a[7] & b[7] & full[7]);
    end else begin
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      nib  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      ovf  = (a[7] & b[7] & ~full[7]) | (~a[7] & ~b[7] & full[7]);
    end
    res   = full[7:0];
    carry = full[8];
    half  = nib[4];
  end
endmodule

// >>> sim/reg_host.sv
`timescale 1ns/1ps
module reg_host (
  input  wire logic        sys_clk,
  output logic      [7:0]  awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic      [31:0] wdata,
  output logic      [3:0]  wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic      [7:0]  araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  logic hung;
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready, hung} = '0;
  end
  // Address and data offered together, each dropped once taken
  task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int   n;
    logic aw;
    logic w;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (awvalid && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw && w) && n < 50);
    do begin
      @(posedge sys_clk);
      n++;
    end while (!bvalid && n < 100);
    r = bvalid ? bresp : 2'bxx;
    hung = hung | !bvalid;
    bready <= 1'b0;
  endtask
  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!arready && n < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!rvalid && n < 100);
    d = rdata;
    r = rvalid ? rresp : 2'bxx;
    hung = hung | !rvalid;
    rready <= 1'b0;
  endtask
endmodule

// >>> sim/test_mcu_arith_logic_unit.sv
`timescale 1ns/1ps
module test_mcu_arith_logic_unit;
  import alu_pkg::*;
  logic        sys_clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          numErrors = 0;
  int          nChecks = 0;
  logic [7:0]  dv [5] = '{8'h00, 8'h7f, 8'hff, 8'h88, 8'h80};
  logic [7:0]  sv [5] = '{8'h80, 8'h01, 8'hff, 8'h08, 8'h80};

  mcu_arith_logic_unit uut (.sys_clk(sys_clk), .resetn(resetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  reg_host host (.sys_clk(sys_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic guard;
    if (host.hung) begin
      numErrors++;
      $display("wrong value handshake expected done seen timeout");
      end_sim();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    host.write({3'h0, a}, d, r);
    guard();
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    host.read({3'h0, a}, d, r);
    guard();
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic settle;
    logic [31:0] v;
    int          n;
    n = 0;
    do begin
      rd(OFF_CMD, v, RESP_OKAY);
      n++;
    end while (v[BUSY_BIT] !== 1'b0 && n < 20);
    if (v[BUSY_BIT] !== 1'b0) begin
      chk("busy", 32'h0, v);
      end_sim();
    end
  endtask

  // Expected result, flags (H S V N Z C) and result register
  function automatic void model(input op_t op, input logic [7:0] d, input logic [7:0] s,
      input logic [5:0] f, output logic [15:0] res, output logic [5:0] ef,
      output logic [4:0] loc);
    logic [8:0]         t;
    logic [4:0]         h;
    logic [16:0]        u;
    logic [7:0]         a, b, r8;
    logic               sb, ci, v;
    logic [15:0]        p, pu;
    logic signed [15:0] ps, pm;
    logic [5:0]         nf, m;
    loc = OFF_OPND;
    if (op inside {OP_ADD, OP_ADC, OP_INC, OP_SUB, OP_DIFF_BORROW, OP_MINUS_ONE,
                   OP_SIGN_FLIP}) begin
      sb = op inside {OP_SUB, OP_DIFF_BORROW, OP_MINUS_ONE, OP_SIGN_FLIP};
      a = (op == OP_SIGN_FLIP) ? ALL_ZERO : d;
      b = (op == OP_SIGN_FLIP) ? d : (op inside {OP_INC, OP_MINUS_ONE}) ? ONE : s;
      ci = (op inside {OP_ADC, OP_DIFF_BORROW}) ? f[FLG_BORROW] : 1'b0;
      t = sb ? {1'b0, a} - {1'b0, b} - ci : {1'b0, a} + {1'b0, b} + ci;
      h = sb ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - ci : {1'b0, a[3:0]} + {1'b0, b[3:0]} + ci;
      v = ((a[7] ^ b[7]) == sb) && (t[7] != a[7]);
      res = {s, t[7:0]};
      nf = {h[4], 1'b0, v, t[7], t[7:0] == 8'h00, t[8]};
      m = (op inside {OP_INC, OP_MINUS_ONE}) ? 6'h0e : 6'h2f;
    end else if (op inside {OP_WADD, OP_WSUB}) begin
      u = (op == OP_WADD) ? {1'b0, d, s} + {9'h0, s} : {1'b0, d, s} - {9'h0, s};
      v = (op == OP_WADD) ? (!d[7] && u[15]) : (d[7] && !u[15]);
      res = u[15:0];
      loc = OFF_WORD;
      nf = {1'b0, u[15] ^ v, v, u[15], u[15:0] == 16'h0, u[16]};
      m = 6'h1f;
    end else if (op < OP_MULU) begin
      r8 = (op == OP_AND) ? d & s : (op inside {OP_OR, OP_SETB}) ? d | s :
           (op == OP_XOR) ? d ^ s : (op == OP_INV) ? ~d : (op == OP_CLRB) ? d & ~s :
           (op == OP_ZM_TEST) ? d : (op == OP_ZERO) ? ALL_ZERO : ALL_ONES;
      res = {s, r8};
      nf = {3'h0, r8[7], r8 == 8'h00, op == OP_INV};
      m = (op == OP_FILL) ? 6'h00 : (op == OP_INV) ? 6'h0f : 6'h0e;
    end else begin
      pu = d * s;
      ps = $signed(d) * $signed(s);
      pm = $signed(d) * $signed({1'b0, s});
      p = (op inside {OP_MULU, OP_FMULU}) ? pu :
          (op inside {OP_PROD_SIGNED, OP_FRAC_SIGNED}) ? ps : pm;
      res = (op inside {OP_FMULU, OP_FRAC_SIGNED, OP_FRAC_MIXED}) ? p << 1 : p;
      loc = OFF_PROD;
      nf = {4'h0, res == 16'h0, p[15]};
      m = 6'h03;
    end
    ef = (f & ~m) | (nf & m);
  endfunction

  initial begin
    op_t         op;
    logic [31:0] v;
    logic [15:0] res;
    logic [5:0]  ef, fl;
    logic [4:0]  loc;
    resetn = 1'b0;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(OFF_FLAGS, v, RESP_OKAY);
    chk("flags reset", 32'h0, v);
    rd(OFF_CMD, v, RESP_OKAY);
    chk("cmd reset", 32'h0, v);
    $display("test reset done");
    for (int i = 0; i < OP_COUNT; i++) begin
      for (int k = 0; k < 5; k++) begin
        for (int j = 0; j < 2; j++) begin
          op = op_t'(i);
          fl = (j == 1) ? 6'h3f : 6'h00;
          wr(OFF_OPND, {16'h0, sv[k], dv[k]}, RESP_OKAY);
          wr(OFF_WORD, {16'h0, dv[k], sv[k]}, RESP_OKAY);
          wr(OFF_FLAGS, {26'h0, fl}, RESP_OKAY);
          wr(OFF_CMD, {27'h0, op}, RESP_OKAY);
          settle();
          model(op, dv[k], sv[k], fl, res, ef, loc);
          rd(loc, v, RESP_OKAY);
          chk(op.name(), {16'h0, res}, v);
          rd(OFF_FLAGS, v, RESP_OKAY);
          chk("flags", {26'h0, ef}, v);
        end
      end
      $display("test opcode %0d done", i);
    end
    wr(5'h14, 32'h0, RESP_SLVERR);
    rd(5'h14, v, RESP_SLVERR);
    chk("unmapped data", 32'h0, v);
    wr(OFF_PROD, 32'h1234, RESP_OKAY);
    rd(OFF_PROD, v, RESP_OKAY);
    chk("product kept", {16'h0, res}, v);
    wr(OFF_OPND, 32'ha53c, RESP_OKAY);
    wr(OFF_CMD, 32'h18, RESP_OKAY);
    settle();
    rd(OFF_OPND, v, RESP_OKAY);
    chk("operand after bad code", 32'ha53c, v);
    $display("test map done");
    end_sim();
  end
endmodule
